// ===== rtl/kfx_regs.svh
// Register offsets, field positions, reset values and mapping constants of the key stream mapper.
// Overview of operation
// - Two segments per encrypted D-field pair.
// - Segment length is tail prefix plus B-field.
// - Segment bits indexed upward from zero.
// - Configs 1a-6: tail bits 8-47 take segment 0-39.
// - Configs 1a-6: non-control tail drops segment 0-39.
// - Configs 1a-6 unprotected: data bit i uses i+40.
// - Config 4a: tail bits 8-87 take segment 0-79.
// - Config 4a: non-control tail drops segment 0-79.
// - Config 4a unprotected: data bit i uses i+80.
// - Config 4b: tail bits 8-127 take segment 0-119.
// - Config 4b: non-control tail drops segment 0-119.
// - Config 4b unprotected: data bit i uses i+120.
// - Single-subfield protected: data bit i uses i+prefix.
// - Double slot data bits per configuration, all encrypted.
// - Full slot data bits per configuration, all encrypted.
// - Half slot data bits per configuration.
// - Long slot data bits for j 640 or 672.
// - Redundancy checks and X-field pass unencrypted.
// - Multisubfield bit i of x uses 80x+i+prefix.
`ifndef KFX_REGS_SVH
`define KFX_REGS_SVH

// Register byte offsets on the plain register port.
`define KFX_CTRL_OFS       4'h0
`define KFX_CMD_OFS        4'h4
`define KFX_STAT_OFS       4'h8
`define KFX_LEN_OFS        4'hc

// Control register field positions.
`define KFX_CFG_LSB        0
`define KFX_CFG_MSB        2
`define KFX_SLOT_LSB       3
`define KFX_SLOT_MSB       5
`define KFX_FMT_LSB        6
`define KFX_FMT_MSB        7
`define KFX_TAILCT_BIT     8
`define KFX_CTRL_RST       32'h0000_0000

// Command register field positions.
`define KFX_CMD_START_BIT  0

// Status and length register field positions.
`define KFX_STAT_BUSY_BIT  0
`define KFX_STAT_DRAIN_BIT 1
`define KFX_STAT_PAIR_BIT  2
`define KFX_STAT_LATE_BIT  3
`define KFX_STAT_IDX_LSB   16
`define KFX_LEN_PFX_LSB    16

// Tail field alignment and prefix lengths.
`define KFX_TAIL_FIRST     8'h08
`define KFX_PFX_NORMAL     8'h28
`define KFX_PFX_4A         8'h50
`define KFX_PFX_4B         8'h78

// Multisubfield geometry: 64 data bits then 16 check bits.
`define KFX_SUB_LEN_LAST   7'h4f
`define KFX_SUB_DATA       7'h40

// B-field data bits per unit of modulation depth, per slot type.
`define KFX_BASE_DOUBLE    13'h0320
`define KFX_BASE_FULL      13'h0140
`define KFX_BASE_HALF      13'h0050
`define KFX_BASE_LONG640   13'h0280
`define KFX_BASE_LONG672   13'h02a0

`endif

// ===== rtl/kfx_pkg.sv
// Types shared by the key stream mapper modules.
package kfx_pkg;

  // Modulation configuration.
  typedef enum logic [2:0] {
    KFX_CFG_1A,
    KFX_CFG_1B,
    KFX_CFG_2,
    KFX_CFG_3,
    KFX_CFG_4A,
    KFX_CFG_4B,
    KFX_CFG_5,
    KFX_CFG_6
  } kfx_cfg_type;

  // Slot type; codes above the last are illegal.
  typedef enum logic [2:0] {
    KFX_SLOT_DOUBLE,
    KFX_SLOT_FULL,
    KFX_SLOT_HALF,
    KFX_SLOT_LONG640,
    KFX_SLOT_LONG672
  } kfx_slot_type;

  // B-field format.
  typedef enum logic [1:0] {
    KFX_FMT_UNPROT,
    KFX_FMT_SINGLE,
    KFX_FMT_MULTI,
    KFX_FMT_ENCODED
  } kfx_fmt_type;

  // Zone of the field bit now offered by the framing logic.
  typedef enum logic [1:0] {
    KFX_ZONE_TAIL,
    KFX_ZONE_DATA,
    KFX_ZONE_PLAIN
  } kfx_zone_type;

  // Segment processing state.
  typedef enum logic [1:0] {
    KFX_ST_IDLE,
    KFX_ST_RUN,
    KFX_ST_DRAIN
  } kfx_state_type;

endpackage : kfx_pkg

// ===== rtl/kfx_len_table.sv
// Registered lookup of tail prefix and B-field data length for a configuration and slot.
`timescale 1ns/1ps
`default_nettype none
`include "kfx_regs.svh"

module kfx_len_table
  import kfx_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  input  wire kfx_cfg_type  i_cfg,
  input  wire kfx_slot_type i_slot,
  output logic [7:0]        o_prefix,
  output logic [12:0]       o_blen
);

  // Tail prefix length set by the configuration.
  function automatic logic [7:0] prefix_of(input kfx_cfg_type cfg);
    unique case (cfg)
      KFX_CFG_4A: prefix_of = `KFX_PFX_4A;
      KFX_CFG_4B: prefix_of = `KFX_PFX_4B;
      default:    prefix_of = `KFX_PFX_NORMAL;
    endcase
  endfunction : prefix_of

  // Bits carried per modulation symbol relative to the binary case.
  function automatic logic [2:0] depth_of(input kfx_cfg_type cfg);
    unique case (cfg)
      KFX_CFG_1A, KFX_CFG_1B: depth_of = 3'h1;
      KFX_CFG_2,  KFX_CFG_4A: depth_of = 3'h2;
      KFX_CFG_3,  KFX_CFG_4B: depth_of = 3'h3;
      KFX_CFG_5:              depth_of = 3'h4;
      KFX_CFG_6:              depth_of = 3'h6;
    endcase
  endfunction : depth_of

  // Binary data length of each slot type; illegal codes fall back to double.
  function automatic logic [12:0] base_of(input kfx_slot_type slot);
    unique case (slot)
      KFX_SLOT_FULL:    base_of = `KFX_BASE_FULL;
      KFX_SLOT_HALF:    base_of = `KFX_BASE_HALF;
      KFX_SLOT_LONG640: base_of = `KFX_BASE_LONG640;
      KFX_SLOT_LONG672: base_of = `KFX_BASE_LONG672;
      default:          base_of = `KFX_BASE_DOUBLE;
    endcase
  endfunction : base_of

  // Both lengths are registered so the mapper sees a steady value.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_prefix <= `KFX_PFX_NORMAL;
      o_blen   <= `KFX_BASE_DOUBLE;
    end else begin
      o_prefix <= prefix_of(i_cfg);
      o_blen   <= 13'(depth_of(i_cfg) * base_of(i_slot));
    end
  end

endmodule : kfx_len_table
`default_nettype wire

// ===== rtl/kfx_keystream_mapper.sv
// Key stream segment to tail and B-field bit mapper with its register port.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "kfx_regs.svh"

module kfx_keystream_mapper
  import kfx_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  input  wire logic        i_ks_bit,
  input  wire logic        i_ks_valid,
  output logic             o_ks_ready,
  input  wire logic        i_fld_bit,
  input  wire logic [1:0]  i_fld_zone,
  input  wire logic        i_fld_last,
  input  wire logic        i_fld_valid,
  output logic             o_fld_ready,
  output logic             o_out_bit,
  output logic             o_out_valid,
  output logic             o_out_last,
  output logic             o_busy,
  output logic             o_seg_done
);

  // Control register contents.
  kfx_cfg_type   cfg;        // Modulation configuration.
  kfx_slot_type  slot;       // Slot type.
  kfx_fmt_type   fmt;        // B-field format.
  logic          tail_ct;    // Tail field carries the encrypted control type.

  // Sequencing state and position counters.
  kfx_state_type state;      // Segment state.
  logic [12:0]   ks_idx;     // Index of the segment bit now offered.
  logic [7:0]    tail_pos;   // Position of the next tail bit.
  logic [12:0]   b_pos;      // Position of the next B-field bit.
  logic [6:0]    sub_pos;    // Position inside the current 80-bit subfield.
  logic          pair_odd;   // High while the second segment of a pair is due.
  logic          late_key;   // Sticky: a field bit wanted a key bit already passed.

  // Lengths from the lookup module.
  logic [7:0]    prefix;     // Tail prefix of the segment.
  logic [12:0]   blen;       // B-field data bits of the segment.
  logic [12:0]   seg_len;    // Whole segment length.

  // Combinational decode of the offered field bit.
  logic          want_key;   // The field bit falls on a mapped position.
  logic          need_key;   // The field bit is combined with a key bit.
  logic [12:0]   key_idx;    // Segment index paired with the field bit.
  logic          take_fld;   // A field bit is consumed this cycle.
  logic          take_ks;    // A key bit is consumed this cycle.
  logic          start_req;  // Software starts a segment.
  logic          run;        // State is running.
  logic          drain;      // State is draining.
  logic          seg_end;    // Drain reaches the segment end.

  // Lengths follow the control register one cycle later.
  kfx_len_table u_len_table (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_cfg      (cfg),
    .i_slot     (slot),
    .o_prefix   (prefix),
    .o_blen     (blen)
  );

  // The segment is the prefix followed by the B-field data span.
  assign seg_len = 13'(prefix) + blen;

  assign run   = (state == KFX_ST_RUN);
  assign drain = (state == KFX_ST_DRAIN);

  // A start command is honoured only between segments.
  assign start_req = i_wr && (i_addr == `KFX_CMD_OFS) &&
                     i_wdata[`KFX_CMD_START_BIT] && (state == KFX_ST_IDLE);

  // Control register write; accepted in any state, so changes also reach a running segment.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cfg     <= kfx_cfg_type'(`KFX_CTRL_RST >> `KFX_CFG_LSB);
      slot    <= KFX_SLOT_DOUBLE;
      fmt     <= KFX_FMT_UNPROT;
      tail_ct <= 1'b0;
    end else if (i_wr && (i_addr == `KFX_CTRL_OFS)) begin
      cfg     <= kfx_cfg_type'(i_wdata[`KFX_CFG_MSB:`KFX_CFG_LSB]);
      slot    <= kfx_slot_type'(i_wdata[`KFX_SLOT_MSB:`KFX_SLOT_LSB]);
      fmt     <= kfx_fmt_type'(i_wdata[`KFX_FMT_MSB:`KFX_FMT_LSB]);
      tail_ct <= i_wdata[`KFX_TAILCT_BIT];
    end
  end

  // Decide whether the offered field bit is mapped and to which segment bit.
  always_comb begin
    want_key = 1'b0;
    key_idx  = 13'h0000;
    unique case (kfx_zone_type'(i_fld_zone))
      KFX_ZONE_TAIL: begin
        // Tail bits from 8 onward take the prefix only for the control type.
        if (tail_ct && (tail_pos >= `KFX_TAIL_FIRST) &&
            (tail_pos < 8'(`KFX_TAIL_FIRST + prefix))) begin
          want_key = 1'b1;
          key_idx  = 13'(tail_pos - `KFX_TAIL_FIRST);
        end
      end
      KFX_ZONE_DATA: begin
        // Check bits of a multisubfield layout stay in clear.
        if ((b_pos < blen) &&
            !((fmt == KFX_FMT_MULTI) && (sub_pos >= `KFX_SUB_DATA))) begin
          want_key = 1'b1;
          key_idx  = 13'(prefix) + b_pos;
        end
      end
      KFX_ZONE_PLAIN: begin
        // Redundancy check and X-field bits are passed unchanged.
        want_key = 1'b0;
      end
      default: begin
        // The unused zone code is passed unchanged.
        want_key = 1'b0;
      end
    endcase
  end

  // A key index outside the segment or already passed cannot be applied.
  assign need_key = want_key && (key_idx < seg_len) && (key_idx >= ks_idx);

  // Field bits move when unmapped or when their own key bit is offered.
  assign o_fld_ready = run && (!need_key || (i_ks_valid && (ks_idx == key_idx)));
  assign take_fld    = o_fld_ready && i_fld_valid;

  // Key bits ahead of the next mapped position are dropped; after the
  // last field bit the rest of the segment is drained.
  assign o_ks_ready = (run && i_fld_valid && need_key) ||
                      (drain && (ks_idx < seg_len));
  assign take_ks    = o_ks_ready && i_ks_valid;

  // The drain ends once every segment bit has been accounted for.
  assign seg_end = drain && (ks_idx >= seg_len);

  // Segment state machine.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state <= KFX_ST_IDLE;
    end else begin
      unique case (state)
        KFX_ST_IDLE: begin
          // Wait for software to start a segment.
          if (start_req) begin
            state <= KFX_ST_RUN;
          end
        end
        KFX_ST_RUN: begin
          // The last field bit of the D-field closes the mapping.
          if (take_fld && i_fld_last) begin
            state <= KFX_ST_DRAIN;
          end
        end
        KFX_ST_DRAIN: begin
          // Leftover key bits have all been discarded.
          if (seg_end) begin
            state <= KFX_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Segment bit index, advanced for every bit taken from the generator.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ks_idx <= 13'h0000;
    end else if (start_req) begin
      ks_idx <= 13'h0000;
    end else if (take_ks) begin
      ks_idx <= ks_idx + 13'h0001;
    end
  end

  // Tail position counter.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      tail_pos <= 8'h00;
    end else if (start_req) begin
      tail_pos <= 8'h00;
    end else if (take_fld && (kfx_zone_type'(i_fld_zone) == KFX_ZONE_TAIL)) begin
      tail_pos <= tail_pos + 8'h01;
    end
  end

  // B-field position and subfield position; check bits advance both.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      b_pos   <= 13'h0000;
      sub_pos <= 7'h00;
    end else if (start_req) begin
      b_pos   <= 13'h0000;
      sub_pos <= 7'h00;
    end else if (take_fld && (kfx_zone_type'(i_fld_zone) == KFX_ZONE_DATA)) begin
      b_pos <= b_pos + 13'h0001;
      // Each subfield spans 80 positions.
      if (sub_pos == `KFX_SUB_LEN_LAST) begin
        sub_pos <= 7'h00;
      end else begin
        sub_pos <= sub_pos + 7'h01;
      end
    end
  end

  // Pair tracking: two segments serve one pair of D-fields.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pair_odd <= 1'b0;
    end else if (seg_end) begin
      pair_odd <= ~pair_odd;
    end
  end

  // Sticky flag for a field bit whose key bit was already gone; a new
  // event in the clear cycle wins over the clear.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      late_key <= 1'b0;
    end else if (run && i_fld_valid && want_key && (key_idx < ks_idx)) begin
      late_key <= 1'b1;
    end else if (i_wr && (i_addr == `KFX_STAT_OFS) && i_wdata[`KFX_STAT_LATE_BIT]) begin
      late_key <= 1'b0;
    end
  end

  // Output bit: the same XOR serves encryption and decryption.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_out_bit   <= 1'b0;
      o_out_valid <= 1'b0;
      o_out_last  <= 1'b0;
    end else begin
      o_out_bit   <= i_fld_bit ^ (need_key & i_ks_bit);
      o_out_valid <= take_fld;
      o_out_last  <= take_fld & i_fld_last;
    end
  end

  // End of segment pulse.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_seg_done <= 1'b0;
    end else begin
      o_seg_done <= seg_end;
    end
  end

  // Busy level follows the state directly.
  assign o_busy = (state != KFX_ST_IDLE);

  // Register read: data stand in the cycle after the read strobe.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= 32'h0000_0000;
      unique case (i_addr)
        `KFX_CTRL_OFS: begin
          o_rdata[`KFX_CFG_MSB:`KFX_CFG_LSB]   <= cfg;
          o_rdata[`KFX_SLOT_MSB:`KFX_SLOT_LSB] <= slot;
          o_rdata[`KFX_FMT_MSB:`KFX_FMT_LSB]   <= fmt;
          o_rdata[`KFX_TAILCT_BIT]             <= tail_ct;
        end
        `KFX_STAT_OFS: begin
          o_rdata[`KFX_STAT_BUSY_BIT]  <= o_busy;
          o_rdata[`KFX_STAT_DRAIN_BIT] <= drain;
          o_rdata[`KFX_STAT_PAIR_BIT]  <= pair_odd;
          o_rdata[`KFX_STAT_LATE_BIT]  <= late_key;
          o_rdata[`KFX_STAT_IDX_LSB +: 13] <= ks_idx;
        end
        `KFX_LEN_OFS: begin
          o_rdata[12:0] <= seg_len;
          o_rdata[`KFX_LEN_PFX_LSB +: 8] <= prefix;
        end
        default: begin
          // Command and unmapped offsets read as zero.
          o_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule : kfx_keystream_mapper
`default_nettype wire

// ===== bench/kfx_mapper_asserts.sv
// Port timing checker of the key stream mapper, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module kfx_mapper_chk (
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic       i_ks_bit,
  input wire logic       i_ks_valid,
  input wire logic       o_ks_ready,
  input wire logic       i_fld_bit,
  input wire logic [1:0] i_fld_zone,
  input wire logic       i_fld_last,
  input wire logic       i_fld_valid,
  input wire logic       o_fld_ready,
  input wire logic       o_out_bit,
  input wire logic       o_out_valid,
  input wire logic       o_out_last,
  input wire logic       o_busy,
  input wire logic       o_seg_done
);
  // All checks use the core clock and rest while reset is low.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic fld_take;  // A field bit is taken at this edge.
  logic ks_take;   // A key bit is taken at this edge.
  assign fld_take = o_fld_ready && i_fld_valid;
  assign ks_take  = o_ks_ready && i_ks_valid;
  a_out_after_take: assert property (fld_take |=> o_out_valid)
    else $error("no result after a field take");
  a_no_stray_out: assert property (!fld_take |=> !o_out_valid)
    else $error("result without a field take");
  a_last_marked: assert property (fld_take && i_fld_last |=> o_out_last)
    else $error("last flag lost");
  a_key_xor_bit: assert property (fld_take && ks_take |=>
    o_out_bit == ($past(i_fld_bit) ^ $past(i_ks_bit)))
    else $error("mapped bit not combined with its key bit");
  a_plain_passes: assert property (fld_take && i_fld_zone[1] |=>
    o_out_bit == $past(i_fld_bit))
    else $error("plain bit altered");
  a_plain_no_key: assert property (fld_take && i_fld_zone[1] |-> !ks_take)
    else $error("key bit spent on a plain bit");
  a_idle_quiet: assert property (!o_busy |-> !o_fld_ready && !o_ks_ready)
    else $error("handshake open while idle");
  a_done_single: assert property (o_seg_done |=> !o_seg_done)
    else $error("segment done longer than one cycle");
  // Main scenarios seen at the ports.
  c_key_xor: cover property (fld_take && ks_take);
  c_key_drop: cover property (ks_take && !fld_take);
  c_seg_done: cover property (o_seg_done);
endmodule : kfx_mapper_chk

bind kfx_keystream_mapper kfx_mapper_chk chk_u (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ks_bit(i_ks_bit),
  .i_ks_valid(i_ks_valid), .o_ks_ready(o_ks_ready), .i_fld_bit(i_fld_bit),
  .i_fld_zone(i_fld_zone), .i_fld_last(i_fld_last), .i_fld_valid(i_fld_valid),
  .o_fld_ready(o_fld_ready), .o_out_bit(o_out_bit), .o_out_valid(o_out_valid),
  .o_out_last(o_out_last), .o_busy(o_busy), .o_seg_done(o_seg_done)
);
`default_nettype wire

// ===== bench/kfx_ks_model.sv
// Key stream generator model: one bit per index, prompt or stalling.
`timescale 1ns/1ps
`default_nettype none
module kfx_ks_model (
  input  wire logic  i_core_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_new,    // Restarts the segment at index zero.
  input  wire logic  i_slow,   // Offers a bit only every fourth cycle without a take.
  input  wire logic  i_ready,
  output logic       o_bit,
  output logic       o_valid,
  output logic [12:0] o_idx
);
  logic [1:0] wait_cnt;  // Stall counter of slow mode.
  logic       gate;      // Slow mode offer, held until taken.
  // Fixed scramble of the index, recomputed by the bench.
  function automatic logic ks_fn(input logic [12:0] k);
    return ^(k & 13'h0b5b) ^ k[2];
  endfunction : ks_fn
  // Index counts bits handed over; bit k is the k-th of the segment.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn || i_new) begin
      o_idx <= 13'h0;
    end else if (o_valid && i_ready) begin
      o_idx <= o_idx + 13'h1;
    end
  end
  // Slow mode raises valid every fourth cycle without a take and holds it until taken.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wait_cnt <= 2'h0;
      gate     <= 1'b0;
    end else if (o_valid && i_ready) begin
      gate <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      gate     <= gate || (wait_cnt == 2'h3);
    end
  end
  assign o_valid = !i_slow || gate;
  // A stalled line shows the inverse bit, never a stale copy.
  assign o_bit = o_valid ? ks_fn(o_idx) : !ks_fn(o_idx);
endmodule : kfx_ks_model
`default_nettype wire

// ===== bench/kfx_keystream_mapper_bench.sv
// Self-checking bench of the key stream mapper across configs and slots.
`timescale 1ns/1ps
`default_nettype none
module kfx_keystream_mapper_bench;
  logic        core_clk, rstn, wr, rd, ks_bit, ks_valid, ks_ready, fld_bit;
  logic        fld_last, fld_valid, fld_ready, out_bit, out_valid, out_last;
  logic        busy, seg_done, ks_new, ks_slow;
  logic [1:0]  fld_zone;
  logic [3:0]  addr;
  logic [12:0] ks_idx;
  logic [31:0] wdata, rdata, seed, rd_val;
  logic [1:0]  exp_q[$];  // Expected {last, bit} per taken field bit.
  int          errors, total_checks;
  int          seg_n;  // Segments completed so far; its parity is the pair bit.

  kfx_keystream_mapper dut_u (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ks_bit(ks_bit),
    .i_ks_valid(ks_valid), .o_ks_ready(ks_ready), .i_fld_bit(fld_bit),
    .i_fld_zone(fld_zone), .i_fld_last(fld_last), .i_fld_valid(fld_valid),
    .o_fld_ready(fld_ready), .o_out_bit(out_bit), .o_out_valid(out_valid),
    .o_out_last(out_last), .o_busy(busy), .o_seg_done(seg_done));
  kfx_ks_model ks_u (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_new(ks_new), .i_slow(ks_slow),
    .i_ready(ks_ready), .o_bit(ks_bit), .o_valid(ks_valid), .o_idx(ks_idx));

  // The 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  // Next random bit from the bench's shift register.
  function automatic logic rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed[0];
  endfunction : rnd
  // Expected key bit for an index.
  function automatic logic kfn(input logic [12:0] k);
    return ^(k & 13'h0b5b) ^ k[2];
  endfunction : kfn
  // B-field data bits: slot base times modulation depth.
  function automatic int blen(input int cfg, input int slot);
    int base[5] = '{800, 320, 80, 640, 672};
    int dep[8] = '{1, 1, 2, 3, 2, 3, 4, 6};
    return base[slot] * dep[cfg];
  endfunction : blen

  // Counts and reports one comparison.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One register write, then an idle cycle.
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : reg_wr
  // One register read; the data stand in the following cycle.
  task automatic reg_rd(input logic [3:0] a);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
    @(posedge core_clk);
  endtask : reg_rd
  // Offers one field bit until taken; k is its key index or -1.
  task automatic send(input logic b, input logic [1:0] z, input logic l, input int k);
    fld_bit <= b; fld_zone <= z; fld_last <= l; fld_valid <= 1'b1;
    for (int n = 0; n < 1000; n++) begin
      @(posedge core_clk);
      if (fld_ready) break;
    end
    exp_q.push_back({l, b ^ (k >= 0 && kfn(k[12:0]))});
  endtask : send

  // Each result is compared with the value queued at its take.
  always @(posedge core_clk) begin
    if (rstn && out_valid) begin
      chk("out", exp_q.size() ? exp_q.pop_front() : 2'bxx, {out_last, out_bit});
    end
  end

  // One whole segment: tail, B-field, X bits, then drain.
  task automatic run_seg(input int cfg, input int slot, input int fmt, input logic tct);
    int pfx, bl, nd, k;
    pfx = cfg == 4 ? 80 : cfg == 5 ? 120 : 40;
    bl = blen(cfg, slot);
    nd = fmt == 1 ? bl - 32 : bl;
    reg_wr(4'h0, (tct << 8) | (fmt << 6) | (slot << 3) | cfg);
    reg_rd(4'hc);
    chk("length", (pfx << 16) | (pfx + bl), rd_val);
    ks_new <= 1'b1;
    reg_wr(4'h4, 32'h1);
    ks_new <= 1'b0;
    for (int t = 0; t < pfx + 12; t++) begin
      k = (tct && t >= 8 && t < 8 + pfx) ? t - 8 : -1;
      send(rnd(), 2'h0, 1'b0, k);
    end
    for (int p = 0; p < bl; p++) begin
      k = (p < nd && (fmt != 2 || p % 80 < 64)) ? pfx + p : -1;
      send(rnd(), p < nd ? 2'h1 : 2'h2, 1'b0, k);
    end
    for (int x = 0; x < 4; x++) send(rnd(), 2'h3, x == 3, -1);
    fld_valid <= 1'b0;
    for (int n = 0; n < 3000; n++) begin
      @(posedge core_clk);
      if (seg_done) break;
    end
    chk("key count", pfx + bl, ks_idx);
    chk("busy after drain", 32'h0, busy);
    seg_n++;
    reg_rd(4'h8);
    chk("status", ((pfx + bl) << 16) | ((seg_n % 2) << 2), rd_val);
    $display("segment cfg %0d slot %0d fmt %0d done", cfg, slot, fmt);
  endtask : run_seg

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (98000) @(posedge core_clk);
    errors++;
    stop_test();
  end

  // Main sequence: reset, register defaults, then every config and slot.
  initial begin
    core_clk = 1'b0; rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0;
    wdata = 32'h0; fld_bit = 1'b0; fld_zone = 2'h0; fld_last = 1'b0;
    fld_valid = 1'b0; ks_new = 1'b0; ks_slow = 1'b0; seed = 32'h73fd4312;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    reg_rd(4'hc);
    chk("reset length", 32'h0028_0348, rd_val);
    reg_rd(4'h2);
    chk("unmapped read", 32'h0, rd_val);
    for (int s = 0; s < 5; s++) begin
      for (int c = 0; c < 8; c++) begin
        ks_slow <= (c == 0);
        run_seg(c, s, (c + s) % 4, rnd());
      end
    end
    stop_test();
  end
endmodule : kfx_keystream_mapper_bench
`default_nettype wire
